/* include/avi_status_pkg.sv */
/*
  Constants for the video infoframe status register bank: register
  offsets, field widths and positions, code values and reset values.
  Assumes an 8-bit register port with byte offsets.
*/
package avi_status_pkg;

  // ==========================================================
  // Register port
  // ==========================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] OFS_ASPECT = 8'h82;
  localparam logic [7:0] OFS_SCALING = 8'h83;
  localparam logic [7:0] OFS_FORMAT = 8'h84;
  localparam logic [7:0] OFS_REPEAT = 8'h85;
  localparam logic [7:0] OFS_TOPBAR_LO = 8'h86;
  localparam logic [7:0] OFS_FLAGS_A = 8'h87;
  localparam logic [7:0] OFS_TOPBAR_HI = 8'h88;
  localparam logic [7:0] OFS_FLAGS_B = 8'h8F;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hF1;

  // ==========================================================
  // Field widths
  // ==========================================================
  localparam int ASPECT_W = 4;
  localparam int SCALING_W = 2;
  localparam int FORMAT_W = 7;
  localparam int REPEAT_W = 4;
  localparam int TOPBAR_W = 16;
  localparam int FLAGS_W = 7;
  localparam int IRQ_W = 8;

  // ==========================================================
  // Code values
  // ==========================================================
  localparam logic [3:0] ASPECT_SAME = 4'h8;
  localparam logic [3:0] ASPECT_4_3 = 4'h9;
  localparam logic [3:0] ASPECT_16_9 = 4'hA;
  localparam logic [3:0] ASPECT_14_9 = 4'hB;
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_HORIZ = 2'h1;
  localparam logic [1:0] SCALE_VERT = 2'h2;
  localparam logic [1:0] SCALE_BOTH = 2'h3;
  localparam logic [3:0] REPEAT_MAX = 4'h9;
  localparam logic [15:0] TOPBAR_NONE = 16'h0000;

  // ==========================================================
  // Change flag and interrupt bit positions
  // ==========================================================
  localparam int FLAG_VIDEO = 0;
  localparam int FLAG_AUDIO = 1;
  localparam int FLAG_SOURCE = 2;
  localparam int FLAG_MPEG = 3;
  localparam int FLAG_PROTECT = 4;
  localparam int IRQ_BAD_REPEAT = 7;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [3:0] RST_ASPECT = 4'h0;
  localparam logic [1:0] RST_SCALING = 2'h0;
  localparam logic [6:0] RST_FORMAT = 7'h00;
  localparam logic [3:0] RST_REPEAT = 4'h0;
  localparam logic [15:0] RST_TOPBAR = 16'h0000;
  localparam logic [6:0] RST_FLAGS = 7'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;

endpackage

/* logic/sticky_flags.sv */
/*
  Bank of sticky flags: hardware pulses set bits, one clear strobe
  drops all of them at once. Assumes set and clear come from logic on
  the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic [W-1:0] set,
  input wire logic clr,
  // State
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // Set beats a clear landing in the same cycle
  always_comb begin
    flags_d = (flags_q & ~{W{clr}}) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule

`default_nettype wire

/* logic/repeat_decode.sv */
/*
  Decodes a pixel repetition code into a send count. Pure logic;
  assumes the code is held stable by the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module repeat_decode
  import avi_status_pkg::*;
(
  // Code in
  input wire logic [avi_status_pkg::REPEAT_W-1:0] code,
  // Decoded
  output logic valid,
  output logic [avi_status_pkg::REPEAT_W-1:0] times
);

  // Reserved codes report no count at all, never a wrapped one
  always_comb begin
    valid = (code <= REPEAT_MAX);
    times = '0;
    if (valid) begin
      times = code + 4'h1;
    end
  end

endmodule

`default_nettype wire

/* logic/avi_infoframe_status_regs.sv */
/*
  Status register bank for fields decoded from received video
  infoframes, plus the shared read-clear packet change flags and a
  masked interrupt. Assumes a packet receiver on the same clock that
  strobes a full set of decoded fields and pulses change events for
  the other packet types, and a register master that reads and
  writes with one-cycle strobes.
*/
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module avi_infoframe_status_regs
  import avi_status_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [avi_status_pkg::ADDR_W-1:0] ADDR,
  input wire logic [avi_status_pkg::DATA_W-1:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [avi_status_pkg::DATA_W-1:0] RD_DATA,
  // Video infoframe from the packet receiver
  input wire logic VIF_STROBE,
  input wire logic [avi_status_pkg::ASPECT_W-1:0] VIF_ASPECT,
  input wire logic [avi_status_pkg::SCALING_W-1:0] VIF_SCALING,
  input wire logic [avi_status_pkg::FORMAT_W-1:0] VIF_FORMAT,
  input wire logic [avi_status_pkg::REPEAT_W-1:0] VIF_REPEAT,
  input wire logic [avi_status_pkg::TOPBAR_W-1:0] VIF_TOP_BAR,
  // Change events of the other packet types, bits 6:1
  input wire logic [avi_status_pkg::FLAGS_W-1:1] PKT_CHANGE,
  // Decoded fields
  output logic [avi_status_pkg::ASPECT_W-1:0] ASPECT_CODE,
  output logic ASPECT_KNOWN,
  output logic [avi_status_pkg::SCALING_W-1:0] SCALING_CODE,
  output logic SCALED_HORIZ,
  output logic SCALED_VERT,
  output logic [avi_status_pkg::FORMAT_W-1:0] FORMAT_CODE,
  output logic [avi_status_pkg::REPEAT_W-1:0] REPEAT_TIMES,
  output logic REPEAT_VALID,
  output logic [avi_status_pkg::TOPBAR_W-1:0] TOP_BAR_LINE,
  output logic NO_TOP_BAR,
  // Flags and interrupt
  output logic [avi_status_pkg::FLAGS_W-1:0] CHANGE_FLAGS,
  output logic IRQ
);

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic aspect_known(input logic [3:0] code);
    aspect_known = (code == ASPECT_SAME) || (code == ASPECT_4_3) ||
                   (code == ASPECT_16_9) || (code == ASPECT_14_9);
  endfunction

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // Field holding registers
  // ==========================================================
  logic [ASPECT_W-1:0] aspect_q;
  logic [ASPECT_W-1:0] aspect_d;
  logic [SCALING_W-1:0] scaling_q;
  logic [SCALING_W-1:0] scaling_d;
  logic [FORMAT_W-1:0] format_q;
  logic [FORMAT_W-1:0] format_d;
  logic [REPEAT_W-1:0] repeat_q;
  logic [REPEAT_W-1:0] repeat_d;
  logic [TOPBAR_W-1:0] topbar_q;
  logic [TOPBAR_W-1:0] topbar_d;
  logic vif_differs;

  // Any field differing from what is held marks a content change
  always_comb begin
    vif_differs = (VIF_ASPECT != aspect_q) ||
                  (VIF_SCALING != scaling_q) ||
                  (VIF_FORMAT != format_q) ||
                  (VIF_REPEAT != repeat_q) ||
                  (VIF_TOP_BAR != topbar_q);
  end

  always_comb begin
    aspect_d = aspect_q;
    scaling_d = scaling_q;
    format_d = format_q;
    repeat_d = repeat_q;
    topbar_d = topbar_q;
    if (VIF_STROBE) begin
      aspect_d = VIF_ASPECT;
      scaling_d = VIF_SCALING;
      format_d = VIF_FORMAT;
      repeat_d = VIF_REPEAT;
      topbar_d = VIF_TOP_BAR;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aspect_q <= RST_ASPECT;
      scaling_q <= RST_SCALING;
      format_q <= RST_FORMAT;
      repeat_q <= RST_REPEAT;
      topbar_q <= RST_TOPBAR;
    end else begin
      aspect_q <= aspect_d;
      scaling_q <= scaling_d;
      format_q <= format_d;
      repeat_q <= repeat_d;
      topbar_q <= topbar_d;
    end
  end

  // ==========================================================
  // Repetition decode
  // ==========================================================
  logic rep_valid;
  logic [REPEAT_W-1:0] rep_times;
  logic in_rep_valid;

  // Decodes the next held code so the count lands with the field
  repeat_decode u_rep_held (
    .code (repeat_d),
    .valid (rep_valid),
    .times (rep_times)
  );

  // Checks the incoming code so a reserved one can raise an event
  repeat_decode u_rep_in (
    .code (VIF_REPEAT),
    .valid (in_rep_valid),
    .times ()
  );

  // ==========================================================
  // Register port decode
  // ==========================================================
  logic rd_flags;
  logic rd_irq;
  logic rd_topbar_lo;
  logic rd_topbar_hi;
  logic wr_mask;

  always_comb begin
    rd_flags = RD_STB && (hit(ADDR, OFS_FLAGS_A) ||
                          hit(ADDR, OFS_FLAGS_B));
    rd_irq = RD_STB && hit(ADDR, OFS_IRQ_STATUS);
    rd_topbar_lo = RD_STB && hit(ADDR, OFS_TOPBAR_LO);
    rd_topbar_hi = RD_STB && hit(ADDR, OFS_TOPBAR_HI);
    wr_mask = WR_STB && hit(ADDR, OFS_IRQ_MASK);
  end

  // ==========================================================
  // Packet change flags
  // ==========================================================
  logic [FLAGS_W-1:0] change_set;
  logic [FLAGS_W-1:0] flags;

  always_comb begin
    change_set = {PKT_CHANGE, 1'b0};
    change_set[FLAG_VIDEO] = VIF_STROBE && vif_differs;
  end

  // One bank feeds every copy, so copies cannot disagree
  sticky_flags #(
    .W (FLAGS_W)
  ) u_change_flags (
    .clk (CORE_CLK),
    .rst_n (RESET_N),
    .set (change_set),
    .clr (rd_flags),
    .flags (flags)
  );

  // ==========================================================
  // Interrupt status and mask
  // ==========================================================
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] mask_d;
  logic irq_q;
  logic irq_d;

  always_comb begin
    irq_set = {1'b0, change_set};
    irq_set[IRQ_BAD_REPEAT] = VIF_STROBE && !in_rep_valid;
  end

  sticky_flags #(
    .W (IRQ_W)
  ) u_irq_status (
    .clk (CORE_CLK),
    .rst_n (RESET_N),
    .set (irq_set),
    .clr (rd_irq),
    .flags (irq_status)
  );

  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = WR_DATA;
    end
    irq_d = |(irq_status & mask_q);
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_q <= RST_MASK;
      irq_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // Top-bar pairing
  // ==========================================================
  // Reading the low byte freezes the high byte, so a new infoframe
  // landing between the two reads cannot tear the 16-bit value.
  logic [7:0] hi_snap_q;
  logic [7:0] hi_snap_d;
  logic snap_vld_q;
  logic snap_vld_d;
  logic [7:0] topbar_hi_view;

  always_comb begin
    hi_snap_d = hi_snap_q;
    snap_vld_d = snap_vld_q;
    if (rd_topbar_lo) begin
      hi_snap_d = topbar_q[15:8];
      snap_vld_d = 1'b1;
    end else if (rd_topbar_hi) begin
      snap_vld_d = 1'b0;
    end
    topbar_hi_view = snap_vld_q ? hi_snap_q : topbar_q[15:8];
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hi_snap_q <= 8'h00;
      snap_vld_q <= 1'b0;
    end else begin
      hi_snap_q <= hi_snap_d;
      snap_vld_q <= snap_vld_d;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // Data stand only in the cycle after the strobe; zero otherwise
  always_comb begin
    rdata_d = READ_IDLE;
    if (RD_STB) begin
      unique case (ADDR)
        OFS_ASPECT: rdata_d = {4'h0, aspect_q};
        OFS_SCALING: rdata_d = {6'h00, scaling_q};
        OFS_FORMAT: rdata_d = {1'b0, format_q};
        OFS_REPEAT: rdata_d = {4'h0, repeat_q};
        OFS_TOPBAR_LO: rdata_d = topbar_q[7:0];
        OFS_TOPBAR_HI: rdata_d = topbar_hi_view;
        OFS_FLAGS_A: rdata_d = {1'b0, flags};
        OFS_FLAGS_B: rdata_d = {1'b0, flags};
        OFS_IRQ_STATUS: rdata_d = irq_status;
        OFS_IRQ_MASK: rdata_d = mask_q;
        default: rdata_d = READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Decoded field outputs
  // ==========================================================
  logic known_q;
  logic known_d;
  logic no_bar_q;
  logic no_bar_d;
  logic [REPEAT_W-1:0] times_q;
  logic [REPEAT_W-1:0] times_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    known_d = aspect_known(aspect_d);
    no_bar_d = (topbar_d == TOPBAR_NONE);
    times_d = rep_times;
    rvalid_d = rep_valid;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      known_q <= 1'b0;
      no_bar_q <= 1'b1;
      times_q <= 4'h0;
      rvalid_q <= 1'b0;
    end else begin
      known_q <= known_d;
      no_bar_q <= no_bar_d;
      times_q <= times_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign RD_DATA = rdata_q;
  assign ASPECT_CODE = aspect_q;
  assign ASPECT_KNOWN = known_q;
  assign SCALING_CODE = scaling_q;
  assign SCALED_HORIZ = scaling_q[0];
  assign SCALED_VERT = scaling_q[1];
  assign FORMAT_CODE = format_q;
  assign REPEAT_TIMES = times_q;
  assign REPEAT_VALID = rvalid_q;
  assign TOP_BAR_LINE = topbar_q;
  assign NO_TOP_BAR = no_bar_q;
  assign CHANGE_FLAGS = flags;
  assign IRQ = irq_q;

endmodule

`default_nettype wire

/* dv/avi_infoframe_status_regs_monitor.sv */
/*
  Checker for the infoframe status bank, watching top ports only.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module avi_infoframe_status_regs_monitor
  import avi_status_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [avi_status_pkg::ADDR_W-1:0] ADDR,
  input wire logic RD_STB,
  input wire logic [avi_status_pkg::DATA_W-1:0] RD_DATA,
  // Receiver
  input wire logic VIF_STROBE,
  input wire logic [avi_status_pkg::FORMAT_W-1:0] VIF_FORMAT,
  input wire logic [avi_status_pkg::REPEAT_W-1:0] VIF_REPEAT,
  input wire logic [avi_status_pkg::TOPBAR_W-1:0] VIF_TOP_BAR,
  input wire logic [avi_status_pkg::FLAGS_W-1:1] PKT_CHANGE,
  // Decoded fields and flags
  input wire logic [avi_status_pkg::ASPECT_W-1:0] ASPECT_CODE,
  input wire logic ASPECT_KNOWN,
  input wire logic [avi_status_pkg::SCALING_W-1:0] SCALING_CODE,
  input wire logic SCALED_HORIZ,
  input wire logic SCALED_VERT,
  input wire logic [avi_status_pkg::FORMAT_W-1:0] FORMAT_CODE,
  input wire logic [avi_status_pkg::REPEAT_W-1:0] REPEAT_TIMES,
  input wire logic REPEAT_VALID,
  input wire logic [avi_status_pkg::TOPBAR_W-1:0] TOP_BAR_LINE,
  input wire logic NO_TOP_BAR,
  input wire logic [avi_status_pkg::FLAGS_W-1:0] CHANGE_FLAGS
);
  import avi_status_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);
  logic rd_flags;
  assign rd_flags = RD_STB && (ADDR == OFS_FLAGS_A || ADDR == OFS_FLAGS_B);

  AST_KNOWN: assert property (
    ASPECT_KNOWN == (ASPECT_CODE[3:2] == 2'b10)) else $error("aspect known");
  AST_SCALE: assert property (
    {SCALED_VERT, SCALED_HORIZ} == SCALING_CODE) else $error("scale bits");
  AST_REPEAT: assert property (VIF_STROBE |=>
    REPEAT_VALID == ($past(VIF_REPEAT) <= REPEAT_MAX) && REPEAT_TIMES ==
    ($past(VIF_REPEAT) <= REPEAT_MAX ? $past(VIF_REPEAT) + 4'h1 : 4'h0))
    else $error("repeat");
  AST_NO_BAR: assert property (
    NO_TOP_BAR == (TOP_BAR_LINE == TOPBAR_NONE)) else $error("no bar");
  AST_FIELDS: assert property (VIF_STROBE |=>
    FORMAT_CODE == $past(VIF_FORMAT) && TOP_BAR_LINE == $past(VIF_TOP_BAR))
    else $error("fields");
  AST_HOLD: assert property (!VIF_STROBE |=>
    $stable(FORMAT_CODE) && $stable(TOP_BAR_LINE)) else $error("hold");
  AST_PKT_SET: assert property (PKT_CHANGE != 6'h00 |=>
    (CHANGE_FLAGS[6:1] & $past(PKT_CHANGE)) == $past(PKT_CHANGE))
    else $error("pkt set");
  AST_VID_SET: assert property (
    VIF_STROBE && VIF_FORMAT != FORMAT_CODE |=> CHANGE_FLAGS[0])
    else $error("video set");
  AST_CLEAR: assert property (
    rd_flags && !VIF_STROBE && PKT_CHANGE == 6'h00 |=> CHANGE_FLAGS == 7'h00)
    else $error("clear");
  AST_RD_FLAGS: assert property (
    rd_flags |=> RD_DATA == {1'b0, $past(CHANGE_FLAGS)}) else $error("rd");
  AST_STICKY: assert property (
    !rd_flags |=> (CHANGE_FLAGS & $past(CHANGE_FLAGS)) == $past(CHANGE_FLAGS))
    else $error("sticky");
endmodule

`default_nettype wire

/* dv/avi_infoframe_status_regs_tb.sv */
/*
  Self-checking bench with an integer model of the status bank.
  Assumes the package, design and monitor are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module avi_infoframe_status_regs_tb;
  import avi_status_pkg::*;
  logic CORE_CLK, RESET_N, WR_STB, RD_STB, VIF_STROBE, IRQ, NO_TOP_BAR;
  logic [7:0] ADDR, WR_DATA, RD_DATA;
  logic [3:0] VIF_ASPECT, VIF_REPEAT, ASPECT_CODE, REPEAT_TIMES;
  logic [1:0] VIF_SCALING, SCALING_CODE;
  logic [6:0] VIF_FORMAT, FORMAT_CODE, CHANGE_FLAGS;
  logic [15:0] VIF_TOP_BAR, TOP_BAR_LINE;
  logic [6:1] PKT_CHANGE;
  logic ASPECT_KNOWN, SCALED_HORIZ, SCALED_VERT, REPEAT_VALID;
  logic [31:0] seed, r;
  int miscompares, checked, cycles;
  int m_asp, m_scl, m_fmt, m_rep, m_bar, m_flg, m_st, m_msk;
  int m_hi;

  avi_infoframe_status_regs dut (
    .CORE_CLK, .RESET_N, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA,
    .VIF_STROBE, .VIF_ASPECT, .VIF_SCALING, .VIF_FORMAT, .VIF_REPEAT,
    .VIF_TOP_BAR, .PKT_CHANGE, .ASPECT_CODE, .ASPECT_KNOWN, .SCALING_CODE,
    .SCALED_HORIZ, .SCALED_VERT, .FORMAT_CODE, .REPEAT_TIMES, .REPEAT_VALID,
    .TOP_BAR_LINE, .NO_TOP_BAR, .CHANGE_FLAGS, .IRQ
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int mrd(logic [7:0] a);
    case (a)
      OFS_ASPECT: return m_asp;
      OFS_SCALING: return m_scl;
      OFS_FORMAT: return m_fmt;
      OFS_REPEAT: return m_rep;
      OFS_TOPBAR_LO: return m_bar & 255;
      OFS_TOPBAR_HI: return m_hi >= 0 ? m_hi : m_bar >> 8;
      OFS_FLAGS_A, OFS_FLAGS_B: return m_flg;
      OFS_IRQ_STATUS: return m_st;
      OFS_IRQ_MASK: return m_msk;
      default: return 0;
    endcase
  endfunction

  task automatic rd(logic [7:0] a);
    int e;
    e = mrd(a);
    @(posedge CORE_CLK);
    RD_STB <= 1'b1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1;
    chk("rd_data", RD_DATA, e);
    if (a == OFS_TOPBAR_LO) m_hi = m_bar >> 8;
    if (a == OFS_TOPBAR_HI) m_hi = -1;
    if (a == OFS_FLAGS_A || a == OFS_FLAGS_B) m_flg = 0;
    if (a == OFS_IRQ_STATUS) m_st = 0;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge CORE_CLK);
    WR_STB <= 1'b1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
    if (a == OFS_IRQ_MASK) m_msk = d;
  endtask

  task automatic vif(int asp, int scl, int fmt, int rep, int bar);
    if (asp != m_asp || scl != m_scl || fmt != m_fmt || rep != m_rep ||
        bar != m_bar) begin
      m_flg |= 1;
      m_st |= 1;
    end
    if (rep > 9) m_st |= 8'h80;
    @(posedge CORE_CLK);
    VIF_STROBE <= 1'b1;
    VIF_ASPECT <= asp[3:0];
    VIF_SCALING <= scl[1:0];
    VIF_FORMAT <= fmt[6:0];
    VIF_REPEAT <= rep[3:0];
    VIF_TOP_BAR <= bar[15:0];
    @(posedge CORE_CLK);
    VIF_STROBE <= 1'b0;
    {m_asp, m_scl, m_fmt, m_rep, m_bar} = {asp, scl, fmt, rep, bar};
  endtask

  task automatic pkt(int m);
    m_flg |= m;
    m_st |= m;
    @(posedge CORE_CLK);
    PKT_CHANGE <= m[6:1];
    @(posedge CORE_CLK);
    PKT_CHANGE <= 6'h00;
  endtask

  // Lets the one-cycle interrupt lag settle before looking
  task automatic outs();
    @(posedge CORE_CLK);
    #1;
    chk("aspect", ASPECT_CODE, m_asp);
    chk("known", ASPECT_KNOWN, m_asp inside {[8:11]});
    chk("scale", {SCALED_VERT, SCALED_HORIZ, SCALING_CODE}, m_scl * 5);
    chk("format", FORMAT_CODE, m_fmt);
    chk("repeat", {REPEAT_VALID, REPEAT_TIMES}, m_rep < 10 ? m_rep + 17 : 0);
    chk("bar", TOP_BAR_LINE, m_bar);
    chk("no_bar", NO_TOP_BAR, m_bar == 0);
    chk("flags", CHANGE_FLAGS, m_flg);
    chk("irq", IRQ, (m_st & m_msk) != 0);
  endtask

  task automatic end_sim();
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    {RESET_N, WR_STB, RD_STB, VIF_STROBE, ADDR, WR_DATA} = '0;
    {VIF_ASPECT, VIF_SCALING, VIF_FORMAT, VIF_REPEAT, VIF_TOP_BAR} = '0;
    PKT_CHANGE = 6'h00;
    {miscompares, checked, cycles} = '0;
    {m_asp, m_scl, m_fmt, m_rep, m_bar, m_flg, m_st, m_msk} = '0;
    m_hi = -1;
    seed = 32'h00012A17;
    repeat (5) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    outs();
    for (int a = 8'h80; a < 8'h92; a++) rd(a[7:0]);
    wr(OFS_FORMAT, 8'hFF);
    wr(OFS_IRQ_MASK, 8'h81);
    rd(OFS_FORMAT);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      vif(8 + i % 4, i % 4, r[6:0], i, i == 3 ? 0 : r[31:16]);
      outs();
      for (int a = 8'h82; a < 8'h89; a++) rd(a[7:0]);
      rd(OFS_FLAGS_B);
      rd(OFS_IRQ_STATUS);
      outs();
    end
    vif(m_asp, m_scl, m_fmt, m_rep, m_bar);
    outs();
    // New infoframe between the paired reads must not tear the value
    rd(OFS_TOPBAR_LO);
    vif(m_asp, m_scl, m_fmt, m_rep, m_bar ^ 16'hFF00);
    rd(OFS_TOPBAR_HI);
    rd(OFS_TOPBAR_HI);
    for (int b = 1; b < 7; b++) begin
      wr(OFS_IRQ_MASK, b % 2 ? 8'h01 << b : 8'h00);
      pkt(1 << b);
      outs();
      rd(b % 2 ? OFS_FLAGS_A : OFS_FLAGS_B);
      rd(OFS_IRQ_STATUS);
      outs();
    end
    pkt(8'h7E);
    @(posedge CORE_CLK);
    RESET_N <= 1'b0;
    {m_asp, m_scl, m_fmt, m_rep, m_bar, m_flg, m_st, m_msk} = '0;
    m_hi = -1;
    @(posedge CORE_CLK);
    #1;
    chk("rst_repeat", {REPEAT_VALID, REPEAT_TIMES}, 0);
    chk("rst_no_bar", NO_TOP_BAR, 1);
    @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    outs();
    rd(OFS_FLAGS_A);
    end_sim();
  end
endmodule

bind avi_infoframe_status_regs avi_infoframe_status_regs_monitor mon (
  .CORE_CLK, .RESET_N, .ADDR, .RD_STB, .RD_DATA, .VIF_STROBE, .VIF_FORMAT,
  .VIF_REPEAT, .VIF_TOP_BAR, .PKT_CHANGE, .ASPECT_CODE, .ASPECT_KNOWN,
  .SCALING_CODE, .SCALED_HORIZ, .SCALED_VERT, .FORMAT_CODE, .REPEAT_TIMES,
  .REPEAT_VALID, .TOP_BAR_LINE, .NO_TOP_BAR, .CHANGE_FLAGS
);

`default_nettype wire
